// file: intexp_cfg.svh
// Register offsets, field positions and reset values of the interrupt expander
`ifndef INTEXP_CFG_SVH
`define INTEXP_CFG_SVH

`define INTEXP_OFF_INT_CLEAR 12'h000
`define INTEXP_OFF_INT_MASK 12'h004
`define INTEXP_OFF_INT_PENDING 12'h008
`define INTEXP_OFF_EXT_CLEAR 12'h010
`define INTEXP_OFF_EXT_MASK 12'h014
`define INTEXP_OFF_EXT_PENDING 12'h018
`define INTEXP_OFF_STATUS 12'h020
`define INTEXP_OFF_IRQ_MASK 12'h024

`define INTEXP_INT_MASK_RST 8'h00
`define INTEXP_EXT_MASK_RST 2'h0
`define INTEXP_INT_USED 8'hEF
`define INTEXP_EXT_PEND_PAD 6'h3F

`define INTEXP_BIT_TX_DONE 7
`define INTEXP_BIT_WORD_SYNC 6
`define INTEXP_BIT_BUSY_IDLE 5
`define INTEXP_BIT_UNUSED 4
`define INTEXP_BIT_RX_DATA 3
`define INTEXP_BIT_SER_RX 2
`define INTEXP_BIT_SER_TX 1
`define INTEXP_BIT_TIMEOUT 0

`define INTEXP_STS_INT 0
`define INTEXP_STS_EXT 1
`define INTEXP_STS_I2C 2
`define INTEXP_STS_RST 3'h0

`endif

// file: intexp_pkg.sv
// Types shared by the interrupt expander modules
package intexp_pkg;
   typedef struct packed {
      logic tx_done;
      logic word_sync;
      logic busy_idle_tone;
      logic unused;
      logic rx_data;
      logic serial_rx;
      logic serial_tx;
      logic timeout;
   } intexp_int_src_t;

   typedef struct packed {
      logic pin_b;
      logic pin_a;
   } intexp_ext_pin_t;
endpackage

// file: intexp_pend_port.sv
// One interrupt control port: pending flags with clear and mask writes
`timescale 1ns/1ps
module intexp_pend_port #(
   parameter int W = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [W-1:0] i_event,
   input wire logic [W-1:0] i_mask_rst,
   input wire logic i_clr_we,
   input wire logic i_mask_we,
   input wire logic [W-1:0] i_wdata,
   output logic [W-1:0] o_pend,
   output logic [W-1:0] o_mask,
   output logic o_req
);
   logic [W-1:0] pend_r;
   logic [W-1:0] pend_nxt;
   logic [W-1:0] mask_r;
   logic [W-1:0] keep;
   wire [W-1:0] mask_eff = i_mask_we ? i_wdata : mask_r;

   // Clear on written zero; masking also clears; event wins over clear
   assign keep = (i_clr_we ? i_wdata : {W{1'b1}}) & (i_mask_we ? i_wdata : {W{1'b1}});
   assign pend_nxt = (pend_r & keep) | (i_event & mask_eff);

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pend_r <= '0;
         mask_r <= '0;
      end else begin
         pend_r <= pend_nxt;
         if (i_mask_we) begin
            mask_r <= i_wdata;
         end
      end
   end

   assign o_pend = pend_r;
   assign o_mask = mask_r;
   assign o_req = |pend_r;
endmodule

// file: intexp_edge_sync.sv
// Two-stage synchroniser and rising-edge pulse for external pins
`timescale 1ns/1ps
module intexp_edge_sync #(
   parameter int W = 2
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [W-1:0] i_pin,
   output logic [W-1:0] o_level,
   output logic [W-1:0] o_rise
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] prev_r;

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
      end else begin
         meta_r <= i_pin;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign o_level = sync_r;
   assign o_rise = sync_r & ~prev_r;
endmodule

// file: intexp_top.sv
// Interrupt expander: internal and external ports, APB registers, CPU line
// ****************************************************************
// Notes on behaviour
// ****************************************************************
// Notes on behaviour
// - Internal sources on bits 7-5, 3-0; 4 unused
// - NOR of three requests drives CPU line
// - Unmasked event latches; masked event ignored
// - Clear write: zero clears, one keeps
// - Mask write: one enables, zero masks+clears
// - Internal sources masked after reset
// - Pending read is active low
// - No priority among sources
// - CPU line low while anything pending
// - One pending flag per source, no count
// - External port: two pins, bits 1,0
// - External pin rising edge latches if enabled
// - External masked at reset, active-low read
`timescale 1ns/1ps
`include "intexp_cfg.svh"
module intexp_top (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire intexp_pkg::intexp_int_src_t i_int_src,
   input wire intexp_pkg::intexp_ext_pin_t i_ext_pin,
   input wire logic i_i2c_int_req,
   output intexp_pkg::intexp_ext_pin_t o_ext_pin_level,
   output logic o_cpu_int_req_n,
   output logic o_irq
);
   import intexp_pkg::*;

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   wire acc = i_psel & i_penable;
   wire wr = acc & i_pwrite & i_pstrb[0];
   wire sel_iclr = i_paddr == `INTEXP_OFF_INT_CLEAR;
   wire sel_imsk = i_paddr == `INTEXP_OFF_INT_MASK;
   wire sel_ipnd = i_paddr == `INTEXP_OFF_INT_PENDING;
   wire sel_eclr = i_paddr == `INTEXP_OFF_EXT_CLEAR;
   wire sel_emsk = i_paddr == `INTEXP_OFF_EXT_MASK;
   wire sel_epnd = i_paddr == `INTEXP_OFF_EXT_PENDING;
   wire sel_sts = i_paddr == `INTEXP_OFF_STATUS;
   wire sel_irqm = i_paddr == `INTEXP_OFF_IRQ_MASK;
   wire mapped = sel_iclr | sel_imsk | sel_ipnd | sel_eclr | sel_emsk | sel_epnd
      | sel_sts | sel_irqm;
   wire ro_hit = sel_ipnd | sel_epnd;
   wire wo_hit = sel_iclr | sel_imsk | sel_eclr | sel_emsk;

   // ****************************************************************
   // Internal port
   // ****************************************************************
   logic [7:0] int_pend;
   logic [7:0] int_mask;
   logic int_req;
   logic [7:0] int_evt;
   assign int_evt = i_int_src & `INTEXP_INT_USED;

   intexp_pend_port #(.W(8)) u_int_port (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_event(int_evt),
      .i_mask_rst(`INTEXP_INT_MASK_RST),
      .i_clr_we(wr & sel_iclr),
      .i_mask_we(wr & sel_imsk),
      .i_wdata(i_pwdata[7:0]),
      .o_pend(int_pend),
      .o_mask(int_mask),
      .o_req(int_req)
   );

   // ****************************************************************
   // External port
   // ****************************************************************
   logic [1:0] ext_level;
   logic [1:0] ext_rise;
   logic [1:0] ext_pend;
   logic [1:0] ext_mask;
   logic ext_req;

   intexp_edge_sync #(.W(2)) u_ext_sync (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_pin(i_ext_pin),
      .o_level(ext_level),
      .o_rise(ext_rise)
   );

   intexp_pend_port #(.W(2)) u_ext_port (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_event(ext_rise),
      .i_mask_rst(`INTEXP_EXT_MASK_RST),
      .i_clr_we(wr & sel_eclr),
      .i_mask_we(wr & sel_emsk),
      .i_wdata(i_pwdata[1:0]),
      .o_pend(ext_pend),
      .o_mask(ext_mask),
      .o_req(ext_req)
   );

   // ****************************************************************
   // Processor line and system interrupt
   // ****************************************************************
   logic cpu_n_r;
   logic [2:0] sts_r;
   logic [2:0] sts_nxt;
   logic [2:0] irqm_r;
   logic [2:0] req_rise;
   logic [2:0] req_prev_r;
   wire [2:0] req_now = {i_i2c_int_req, ext_req, int_req};
   wire sts_clr_we = wr & sel_sts;
   wire [2:0] sts_keep = sts_clr_we ? ~i_pwdata[2:0] : 3'h7;

   assign req_rise = req_now & ~req_prev_r;
   assign sts_nxt = (sts_r & sts_keep) | req_rise;

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cpu_n_r <= 1'b1;
         sts_r <= `INTEXP_STS_RST;
         irqm_r <= `INTEXP_STS_RST;
         req_prev_r <= 3'h0;
      end else begin
         cpu_n_r <= ~(int_req | ext_req | i_i2c_int_req);
         sts_r <= sts_nxt;
         req_prev_r <= req_now;
         if (wr & sel_irqm) begin
            irqm_r <= i_pwdata[2:0];
         end
      end
   end

   assign o_cpu_int_req_n = cpu_n_r;
   assign o_irq = |(sts_r & irqm_r);
   assign o_ext_pin_level = ext_level;

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (sel_ipnd) begin
         rdata_nxt[7:0] = ~int_pend;
      end else if (sel_epnd) begin
         rdata_nxt[7:0] = {`INTEXP_EXT_PEND_PAD, ~ext_pend};
      end else if (sel_sts) begin
         rdata_nxt[2:0] = sts_r;
      end else if (sel_irqm) begin
         rdata_nxt[2:0] = irqm_r;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (i_psel & ~i_penable & ~i_pwrite) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign o_prdata = rdata_r;
   assign o_pready = 1'b1;
   assign o_pslverr = acc & (~mapped | (i_pwrite & ro_hit) | (~i_pwrite & wo_hit));
endmodule

// file: intexp_checker.sv
// Port checker of the interrupt expander
`timescale 1ns/1ps
`include "intexp_cfg.svh"
module intexp_checker (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] o_prdata,
   input wire logic o_pslverr,
   input wire intexp_pkg::intexp_ext_pin_t i_ext_pin,
   input wire logic i_i2c_int_req,
   input wire intexp_pkg::intexp_ext_pin_t o_ext_pin_level,
   input wire logic o_cpu_int_req_n
);
   import intexp_pkg::*;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   wire rd_set = i_psel && !i_penable && !i_pwrite;
   wire wr_acc = i_psel && i_penable && i_pwrite;
   nor_line_a: assert property (i_i2c_int_req |=> !o_cpu_int_req_n)
      else $error("cpu line not low");
   i2c_hold_a: assert property (i_i2c_int_req [*2] |-> !o_cpu_int_req_n)
      else $error("cpu line rose early");
   line_release_a: assert property ($rose(o_cpu_int_req_n) |-> !$past(i_i2c_int_req))
      else $error("cpu line released");
   reset_masked_a: assert property ($fell(i_sys_rst) ##1 (!i_i2c_int_req && !i_psel) [*2]
      |=> o_cpu_int_req_n) else $error("source live after reset");
   pend_rdonly_a: assert property (wr_acc && i_paddr == `INTEXP_OFF_INT_PENDING
      |-> o_pslverr) else $error("pending write accepted");
   unused_bit_a: assert property (rd_set && i_paddr == `INTEXP_OFF_INT_PENDING
      |=> o_prdata[4] && o_prdata[31:8] == 24'h000000) else $error("bad bit 4");
   ext_pad_a: assert property (rd_set && i_paddr == `INTEXP_OFF_EXT_PENDING
      |=> o_prdata[7:2] == 6'h3F) else $error("bad ext pad");
   sync_delay_a: assert property (!$past(i_sys_rst) && !$past(i_sys_rst, 2)
      |-> o_ext_pin_level == $past(i_ext_pin, 2)) else $error("bad sync");
   cover property (i_i2c_int_req ##1 !o_cpu_int_req_n);
   cover property (rd_set && i_paddr == `INTEXP_OFF_EXT_PENDING);
   cover property ($fell(o_cpu_int_req_n));
endmodule
bind intexp_top intexp_checker chk (.i_sys_clk, .i_sys_rst, .i_psel, .i_penable,
   .i_pwrite, .i_paddr, .o_prdata, .o_pslverr, .i_ext_pin, .i_i2c_int_req,
   .o_ext_pin_level, .o_cpu_int_req_n);

// file: intexp_cpu_model.sv
// Processor interrupt input: samples the active-low request level
`timescale 1ns/1ps
module intexp_cpu_model (
   input wire logic i_sys_clk,
   input wire logic i_cpu_int_req_n,
   output logic o_seen
);
   always_ff @(posedge i_sys_clk) begin
      o_seen <= !i_cpu_int_req_n;
   end
endmodule

// file: interrupt_expander_tb.sv
// Self-checking bench of the interrupt expander
`timescale 1ns/1ps
`include "intexp_cfg.svh"
module interrupt_expander_tb;
   import intexp_pkg::*;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, i2c = 0, err;
   logic [11:0] addr = 0;
   logic [31:0] wd = 0, rd;
   intexp_int_src_t src = '0;
   intexp_ext_pin_t pin = '0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, cpu_n, irq, seen;
   wire logic [1:0] lvl;
   int fails = 0, check_count = 0, seed = 72186, r, m_ip = 0, m_ep = 0;
   always #10 clk = ~clk;
   intexp_top DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .i_pstrb(4'hF), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_int_src(src), .i_ext_pin(pin),
      .i_i2c_int_req(i2c), .o_ext_pin_level(lvl), .o_cpu_int_req_n(cpu_n), .o_irq(irq));
   intexp_cpu_model cpu (.i_sys_clk(clk), .i_cpu_int_req_n(cpu_n), .o_seen(seen));
   task summarize;
      if (fails == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask
   task tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1;
      pwr <= w;
      addr <= a;
      wd <= d;
      tick(1);
      pen <= 1;
      n = 0;
      do begin
         tick(1);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      pen <= 0;
      if (n >= 50) begin
         fails++;
         summarize();
      end
      tick(1);
   endtask
   task pulse(input logic [7:0] s);
      src <= s;
      tick(1);
      src <= '0;
      tick(2);
   endtask
   initial begin
      tick(20);
      rst <= 0;
      tick(1);
      apb(0, `INTEXP_OFF_INT_PENDING, 0);
      chk("int_pend", 32'hFF, rd);
      apb(0, `INTEXP_OFF_EXT_PENDING, 0);
      chk("ext_pend", 32'hFF, rd);
      for (int b = 0; b < 8; b++) begin
         r = $random(seed);
         apb(1, `INTEXP_OFF_INT_MASK, r[7:0]);
         pulse(8'h01 << b);
         pulse(8'h01 << b);
         if (r[b] && b != 4) m_ip = 1 << b;
         apb(0, `INTEXP_OFF_INT_PENDING, 0);
         chk("int_pend", ~m_ip & 8'hFF, rd);
         chk("cpu_n", !m_ip, cpu_n);
         apb(1, b[0] ? `INTEXP_OFF_INT_MASK : `INTEXP_OFF_INT_CLEAR, ~(1 << b));
         m_ip = 0;
         apb(0, `INTEXP_OFF_INT_PENDING, 0);
         chk("int_clr", 32'hFF, rd);
      end
      apb(1, `INTEXP_OFF_INT_MASK, 1);
      pulse(8'h01);
      // Event only in the access cycle of the clear, with the flag already set
      psel <= 1;
      pwr <= 1;
      addr <= `INTEXP_OFF_INT_CLEAR;
      wd <= 0;
      tick(1);
      pen <= 1;
      src <= 8'h01;
      tick(1);
      psel <= 0;
      pen <= 0;
      src <= '0;
      tick(1);
      apb(0, `INTEXP_OFF_INT_PENDING, 0);
      chk("evt_wins", 32'hFE, rd);
      apb(1, `INTEXP_OFF_EXT_MASK, 1);
      apb(1, `INTEXP_OFF_STATUS, 7);
      pin <= 2'b11;
      tick(6);
      chk("pin_level", 3, lvl);
      chk("irq_off", 0, irq);
      apb(1, `INTEXP_OFF_IRQ_MASK, 2);
      chk("irq_on", 1, irq);
      apb(0, `INTEXP_OFF_STATUS, 0);
      chk("status", 2, rd);
      apb(1, `INTEXP_OFF_STATUS, 2);
      chk("irq_clr", 0, irq);
      apb(0, `INTEXP_OFF_EXT_PENDING, 0);
      chk("ext_pend", 32'hFE, rd);
      for (int k = 0; k < 4 && seen; k++) begin
         apb(0, `INTEXP_OFF_INT_PENDING, 0);
         apb(1, `INTEXP_OFF_INT_CLEAR, rd);
         apb(0, `INTEXP_OFF_EXT_PENDING, 0);
         apb(1, `INTEXP_OFF_EXT_CLEAR, rd);
         tick(2);
      end
      chk("cpu_n", 1, cpu_n);
      i2c <= 1;
      tick(2);
      chk("cpu_n_i2c", 0, cpu_n);
      i2c <= 0;
      apb(0, 12'h0FC, 0);
      chk("unmapped", 1, err);
      chk("cpu_n", 1, cpu_n);
      summarize();
   end
endmodule
